/* design/flic_top.sv */
// four-level interrupt controller with apb registers and cpu request port
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module flic_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral flags, levels
    input wire logic timer_a_overflow_flag,
    input wire logic timer_b_overflow_flag,
    input wire logic brownout_flag,
    input wire logic watchdog_overflow_flag,
    input wire logic clock_alarm_flag,
    input wire logic keypad_flag,
    input wire logic [1:0] comparator_flag,
    input wire logic uart_tx_done_flag,
    input wire logic uart_rx_done_flag,
    input wire logic framing_error_flag,
    input wire logic line_pause_flag,
    input wire logic overrun_flag,
    // cpu core
    input wire logic instr_start,
    input wire logic irq_ack,
    input wire logic irq_return,
    input wire logic power_down,
    output logic irq_request,
    output logic [15:0] irq_vector,
    output flic_pkg::flic_level_t irq_level,
    output logic wake_up
);
    import flic_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] irq_enable_reg_a;
    logic [7:0] irq_enable_reg_b;
    logic [7:0] priority_low_reg_a;
    logic [7:0] priority_high_reg_a;
    logic [7:0] priority_low_reg_b;
    logic [7:0] priority_high_reg_b;
    logic [7:0] uart_status_reg;
    logic [NLVL-1:0] in_service;
    logic [2:0] req_src;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    wire setup_phase = psel && !penable;
    wire write_take = psel && penable && pready && pwrite;
    wire hit_enable_a = paddr == OFS_ENABLE_A;
    wire hit_enable_b = paddr == OFS_ENABLE_B;
    wire hit_prio_low_a = paddr == OFS_PRIO_LOW_A;
    wire hit_prio_high_a = paddr == OFS_PRIO_HIGH_A;
    wire hit_prio_low_b = paddr == OFS_PRIO_LOW_B;
    wire hit_prio_high_b = paddr == OFS_PRIO_HIGH_B;
    wire hit_uart_status = paddr == OFS_UART_STATUS;
    wire hit_state = paddr == OFS_STATE;
    wire hit_any = hit_enable_a || hit_enable_b || hit_prio_low_a || hit_prio_high_a
        || hit_prio_low_b || hit_prio_high_b || hit_uart_status || hit_state;
    wire [7:0] wbyte = pwdata[7:0];

    // state view: in-service levels, pending request and its source
    wire [7:0] state_view = {irq_request, req_src, in_service};

    wire [7:0] read_byte =
        hit_enable_a ? irq_enable_reg_a :
        hit_enable_b ? irq_enable_reg_b :
        hit_prio_low_a ? priority_low_reg_a :
        hit_prio_high_a ? priority_high_reg_a :
        hit_prio_low_b ? priority_low_reg_b :
        hit_prio_high_b ? priority_high_reg_b :
        hit_uart_status ? uart_status_reg :
        hit_state ? state_view : 8'h00;

    // no wait state: data and error are fixed in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                prdata <= {24'h00_0000, pwrite ? 8'h00 : read_byte};
                pslverr <= !hit_any;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable_reg_a <= RESET_REG;
            irq_enable_reg_b <= RESET_REG;
            priority_low_reg_a <= RESET_REG;
            priority_high_reg_a <= RESET_REG;
            priority_low_reg_b <= RESET_REG;
            priority_high_reg_b <= RESET_REG;
            uart_status_reg <= RESET_REG;
        end else if (write_take) begin
            if (hit_enable_a) irq_enable_reg_a <= wbyte & MASK_REG_A;
            if (hit_enable_b) irq_enable_reg_b <= wbyte & MASK_REG_B;
            if (hit_prio_low_a) priority_low_reg_a <= wbyte & MASK_PRIO_A;
            if (hit_prio_high_a) priority_high_reg_a <= wbyte & MASK_PRIO_A;
            if (hit_prio_low_b) priority_low_reg_b <= wbyte & MASK_REG_B;
            if (hit_prio_high_b) priority_high_reg_b <= wbyte & MASK_REG_B;
            if (hit_uart_status) uart_status_reg <= wbyte & MASK_UART_STATUS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request collection

    wire uart_split = uart_status_reg[BIT_UART_SPLIT];
    wire uart_errors = uart_status_reg[BIT_UART_ERRORS]
        && (framing_error_flag || line_pause_flag || overrun_flag);

    logic [NSRC-1:0] raw;
    assign raw[SRC_BROWNOUT] = brownout_flag;
    assign raw[SRC_WATCHDOG] = watchdog_overflow_flag || clock_alarm_flag;
    assign raw[SRC_TIMER_A] = timer_a_overflow_flag;
    assign raw[SRC_KEYPAD] = keypad_flag;
    assign raw[SRC_TIMER_B] = timer_b_overflow_flag;
    assign raw[SRC_COMPARATOR] = |comparator_flag;
    assign raw[SRC_UART_TX] = uart_split && uart_tx_done_flag;
    assign raw[SRC_UART_RX] = uart_rx_done_flag || (!uart_split && uart_tx_done_flag)
        || uart_errors;

    wire global_enable = irq_enable_reg_a[BIT_GLOBAL_ENABLE];

    flic_arb_if arb_bus ();

    logic [NSRC-1:0] enabled;

    genvar s;
    generate
        for (s = 0; s < NSRC; s++) begin : g_src
            wire en_bit = SRC_IN_SET_B[s] ? irq_enable_reg_b[SRC_BIT[s]]
                                          : irq_enable_reg_a[SRC_BIT[s]];
            wire hi_bit = SRC_IN_SET_B[s] ? priority_high_reg_b[SRC_BIT[s]]
                                          : priority_high_reg_a[SRC_BIT[s]];
            wire lo_bit = SRC_IN_SET_B[s] ? priority_low_reg_b[SRC_BIT[s]]
                                          : priority_low_reg_a[SRC_BIT[s]];
            assign enabled[s] = raw[s] && en_bit;
            assign arb_bus.req[s] = enabled[s] && global_enable;
            assign arb_bus.lvl[s] = {hi_bit, lo_bit};
        end
    endgenerate

    flic_arbiter u_arbiter (
        .bus(arb_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // preemption against the active level

    logic any_active;
    flic_level_t active_lvl;
    logic [NLVL-1:0] top_active;

    always_comb begin
        any_active = |in_service;
        active_lvl = 2'h0;
        top_active = 4'h0;
        for (int l = 0; l < NLVL; l++) begin
            if (in_service[l]) begin
                active_lvl = l[1:0];
                top_active = 4'h1 << l;
            end
        end
    end

    // level 3 active leaves nothing above it
    wire may_take = arb_bus.found
        && (!any_active || (arb_bus.win_lvl > active_lvl));

    ////////////////////////////////////////////////////////////////////////
    // request to the core and level tracking

    wire ack_take = irq_ack && irq_request;
    wire [NLVL-1:0] ack_set = ack_take ? (4'h1 << irq_level) : 4'h0;
    wire [NLVL-1:0] ret_clear = irq_return ? top_active : 4'h0;
    wire [NLVL-1:0] next_in_service = (in_service & ~ret_clear) | ack_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_service <= 4'h0;
        end else begin
            in_service <= next_in_service;
        end
    end

    // request is settled at each instruction start and dropped on acceptance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_request <= 1'b0;
            irq_vector <= 16'h0000;
            irq_level <= 2'h0;
            req_src <= 3'h0;
        end else if (ack_take) begin
            irq_request <= 1'b0;
        end else if (instr_start) begin
            irq_request <= may_take;
            if (may_take) begin
                irq_vector <= SRC_VECTOR[arb_bus.win];
                irq_level <= arb_bus.win_lvl;
                req_src <= arb_bus.win;
            end
        end else if (!global_enable) begin
            irq_request <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-down wake

    wire wake_hit = power_down && global_enable && |(enabled & SRC_WAKE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_up <= 1'b0;
        end else begin
            wake_up <= wake_hit;
        end
    end
endmodule

/* inc/flic_pkg.sv */
// constants and types of the four-level interrupt controller
// Summary of operation
// - four priority levels for every source
// - high and low bits form level 0..3
// - each source has its own enable bit
// - global enable clear blocks all service
// - only strictly higher level preempts running routine
// - level 3 routine is never interrupted
// - higher pending level is served first
// - fixed ranking resolves only equal levels
// - eight causes: timers, uart, brownout, watchdog, keypad, comparators
// - timers vector 000b/001b, ranks 3/5, no wake
// - brownout 002b rank 1, watchdog 0053 rank 2, wake
// - keypad 003b rank 4, comparator 0043 rank 6, wake
// - enable and priority bits share one position
// - uart status bit 5 splits combined request
// - uart transmit request only with status bit 5
// - uart status bit 0 adds error causes
// - only wake-capable enabled sources leave power down
package flic_pkg;

    localparam int NSRC = 8;
    localparam int NLVL = 4;

    // apb register byte offsets
    localparam logic [7:0] OFS_ENABLE_A = 8'h00;
    localparam logic [7:0] OFS_ENABLE_B = 8'h04;
    localparam logic [7:0] OFS_PRIO_LOW_A = 8'h08;
    localparam logic [7:0] OFS_PRIO_HIGH_A = 8'h0c;
    localparam logic [7:0] OFS_PRIO_LOW_B = 8'h10;
    localparam logic [7:0] OFS_PRIO_HIGH_B = 8'h14;
    localparam logic [7:0] OFS_UART_STATUS = 8'h18;
    localparam logic [7:0] OFS_STATE = 8'h1c;

    // writable bits and reset values
    localparam logic [7:0] MASK_REG_A = 8'hfa;
    localparam logic [7:0] MASK_REG_B = 8'h46;
    localparam logic [7:0] MASK_PRIO_A = 8'h7a;
    localparam logic [7:0] MASK_UART_STATUS = 8'h21;
    localparam logic [7:0] RESET_REG = 8'h00;

    // field positions
    localparam int BIT_GLOBAL_ENABLE = 7;
    localparam int BIT_UART_SPLIT = 5;
    localparam int BIT_UART_ERRORS = 0;

    // sources in ranking order: index 0 is ranking 1
    localparam int SRC_BROWNOUT = 0;
    localparam int SRC_WATCHDOG = 1;
    localparam int SRC_TIMER_A = 2;
    localparam int SRC_KEYPAD = 3;
    localparam int SRC_TIMER_B = 4;
    localparam int SRC_COMPARATOR = 5;
    localparam int SRC_UART_TX = 6;
    localparam int SRC_UART_RX = 7;

    // which enable/priority set a source uses (1 = second set)
    localparam logic [NSRC-1:0] SRC_IN_SET_B = 8'h68;
    // bit position inside the set, shared by enable and priority
    localparam int SRC_BIT [NSRC] = '{5, 6, 1, 1, 3, 2, 6, 4};
    localparam logic [15:0] SRC_VECTOR [NSRC] =
        '{16'h002b, 16'h0053, 16'h000b, 16'h003b, 16'h001b, 16'h0043, 16'h006b, 16'h0023};
    localparam logic [NSRC-1:0] SRC_WAKE = 8'h2b;

    typedef logic [1:0] flic_level_t;

endpackage

/* inc/flic_arb_if.sv */
// carrier between request collection and the priority arbiter
`timescale 1ns/1ps
interface flic_arb_if;
    import flic_pkg::*;
    logic [NSRC-1:0] req;
    flic_level_t lvl [NSRC];
    logic found;
    logic [2:0] win;
    flic_level_t win_lvl;

    modport arb (input req, input lvl, output found, output win, output win_lvl);
    modport ctl (output req, output lvl, input found, input win, input win_lvl);
endinterface

/* design/flic_arbiter.sv */
// priority arbiter: highest level first, then lowest ranking index
`timescale 1ns/1ps
module flic_arbiter (
    flic_arb_if.arb bus
);
    import flic_pkg::*;

    logic [NSRC-1:0] hit [NLVL];
    logic [NLVL-1:0] any;

    genvar l, s;
    generate
        for (l = 0; l < NLVL; l++) begin : g_lvl
            for (s = 0; s < NSRC; s++) begin : g_src
                assign hit[l][s] = bus.req[s] && (bus.lvl[s] == flic_level_t'(l));
            end
            assign any[l] = |hit[l];
        end
    endgenerate

    always_comb begin
        bus.found = |any;
        bus.win = 3'h0;
        bus.win_lvl = 2'h0;
        for (int lv = 0; lv < NLVL; lv++) begin
            if (any[lv]) begin
                bus.win_lvl = lv[1:0];
            end
        end
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (hit[bus.win_lvl][i]) begin
                bus.win = i[2:0];
            end
        end
    end
endmodule

/* verif/flic_assertions.sv */
// concurrent checks on the interrupt controller's ports
`timescale 1ns/1ps
module flic_assertions (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // cpu
    input wire logic instr_start,
    input wire logic irq_ack,
    input wire logic irq_return,
    input wire logic power_down,
    input wire logic irq_request,
    input wire logic [15:0] irq_vector,
    input wire flic_pkg::flic_level_t irq_level,
    input wire logic wake_up
);
    import flic_pkg::*;
    logic top_busy;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a level 3 routine runs from its acceptance to the next return
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) top_busy <= 1'b0;
        else if (irq_ack && irq_request && irq_level == 2'h3) top_busy <= 1'b1;
        else if (irq_return) top_busy <= 1'b0;
    a_ready_latency: assert property (psel && !penable |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_rdata_width: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    a_req_at_start: assert property ($rose(irq_request) |-> $past(instr_start))
        else $error("request outside instruction start");
    a_ack_clears_req: assert property (irq_request && irq_ack && !instr_start |=> !irq_request)
        else $error("request kept after ack");
    a_vector_known: assert property (irq_request |-> irq_vector inside {16'h000b, 16'h001b,
        16'h002b, 16'h003b, 16'h0043, 16'h0053, 16'h0023, 16'h006b})
        else $error("unknown vector");
    a_top_not_preempted: assert property (top_busy && !irq_return |=> !$rose(irq_request))
        else $error("level 3 routine preempted");
    a_wake_needs_pd: assert property (wake_up |-> $past(power_down))
        else $error("wake outside power down");
    c_accept: cover property (irq_request && irq_ack);
    c_wake: cover property (wake_up);
    c_slverr: cover property (pready && pslverr);
endmodule
bind flic_top flic_assertions u_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready,
    .pslverr, .instr_start, .irq_ack, .irq_return, .power_down, .irq_request, .irq_vector,
    .irq_level, .wake_up);

/* verif/flic_cpu_model.sv */
// core model: starts instructions and accepts requests after a set delay
`timescale 1ns/1ps
module flic_cpu_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control
    input wire logic run,
    input wire logic [3:0] ack_dly,
    // controller side
    input wire logic irq_request,
    output logic instr_start,
    output logic irq_ack
);
    logic [3:0] wait_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_start <= 1'b0;
            irq_ack <= 1'b0;
            wait_cnt <= 4'h0;
        end else begin
            instr_start <= run && !irq_request;
            irq_ack <= 1'b0;
            if (irq_request && !irq_ack && wait_cnt >= ack_dly) begin
                irq_ack <= 1'b1;
                wait_cnt <= 4'h0;
            end else if (irq_request && !irq_ack) begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

/* verif/tb.sv */
// self-checking bench of the four-level interrupt controller
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
    import flic_pkg::*;
    logic pclk, pready, pslverr, instr_start, irq_ack, irq_request, wake_up, err;
    logic presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, irq_return = 0;
    logic power_down = 0;
    logic [7:0] paddr = 0, fl = 0;
    logic [4:0] alt = 0;
    logic [3:0] dly = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] irq_vector;
    flic_level_t irq_level;
    flic_level_t lv [NSRC];
    logic [17:0] exq [$];
    logic [17:0] exp_note;
    int n_mismatch = 0, samples_checked = 0;
    localparam logic [7:0] MSK [9] = '{MASK_REG_A, MASK_REG_B, MASK_PRIO_A, MASK_PRIO_A,
        MASK_REG_B, MASK_REG_B, MASK_UART_STATUS, 8'h00, 8'h00};
    localparam int ALT_SRC [5] = '{SRC_WATCHDOG, SRC_COMPARATOR, SRC_UART_RX, SRC_UART_RX,
        SRC_UART_RX};
    flic_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .timer_a_overflow_flag(fl[2]), .timer_b_overflow_flag(fl[4]),
        .brownout_flag(fl[0]), .watchdog_overflow_flag(fl[1]), .clock_alarm_flag(alt[0]),
        .keypad_flag(fl[3]), .comparator_flag({alt[1], fl[5]}), .uart_tx_done_flag(fl[6]),
        .uart_rx_done_flag(fl[7]), .framing_error_flag(alt[2]), .line_pause_flag(alt[3]),
        .overrun_flag(alt[4]), .instr_start, .irq_ack, .irq_return, .power_down,
        .irq_request, .irq_vector, .irq_level, .wake_up);
    flic_cpu_model cpu (.pclk, .presetn, .run, .ack_dly(dly), .irq_request, .instr_start,
        .irq_ack);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #800000;
        n_mismatch++;
        wrap_up();
    end
    // every acceptance is matched against the oldest expectation
    always @(posedge pclk) begin
        if (irq_request === 1'b1 && irq_ack === 1'b1) begin
            if (exq.size() > 0) begin
                exp_note = exq.pop_front();
                `CHK({irq_vector, irq_level}, exp_note)
            end else `CHK(1'b1, 1'b0)
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic setup_regs(input logic [7:0] en, input logic ge);
        logic [7:0] r [6];
        r = '{default: 8'h00};
        for (int s = 0; s < NSRC; s++) begin
            r[SRC_IN_SET_B[s]][SRC_BIT[s]] = en[s];
            r[2 + 2 * SRC_IN_SET_B[s]][SRC_BIT[s]] = lv[s][0];
            r[3 + 2 * SRC_IN_SET_B[s]][SRC_BIT[s]] = lv[s][1];
        end
        r[0][BIT_GLOBAL_ENABLE] = ge;
        for (int i = 0; i < 6; i++) apb(1'b1, 8'(4 * i), {24'h0, r[i]});
    endtask
    task automatic serve(input logic [15:0] v, input flic_level_t l, input logic ret);
        int n = 0;
        exq.push_back({v, l});
        dly <= 4'($urandom % 4);
        run <= 1'b1;
        do @(posedge pclk); while (!(irq_request === 1'b1 && irq_ack === 1'b1) && ++n < 60);
        run <= 1'b0;
        irq_return <= ret;
        @(posedge pclk);
        irq_return <= 1'b0;
        if (n >= 60) begin
            exq.delete();
            `CHK(n, 0)
        end
    endtask
    task automatic quiet();
        run <= 1'b1;
        repeat (20) @(posedge pclk);
        run <= 1'b0;
        `CHK(irq_request, 1'b0)
    endtask
    task automatic ret_pulse();
        irq_return <= 1'b1;
        @(posedge pclk);
        irq_return <= 1'b0;
    endtask
    function automatic int pick(input logic [7:0] p);
        int w = -1;
        for (int s = 0; s < NSRC; s++) if (p[s] && (w < 0 || lv[s] > lv[w])) w = s;
        return w;
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        logic [7:0] p;
        int w;
        w = $urandom(13074);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            if (i == 7) continue;
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rd, 32'h0)
            apb(1'b1, 8'(4 * i), 32'hffffffff);
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rd, {24'h0, MSK[i]})
            `CHK(err, i == 8)
        end
        for (int r = 0; r < 4; r++) begin
            foreach (lv[s]) lv[s] = flic_level_t'($urandom);
            p = 8'($urandom) | 8'h01;
            setup_regs(p, 1'b1);
            fl <= 8'hff;
            while (p != 8'h00) begin
                w = pick(p);
                serve(SRC_VECTOR[w], lv[w], 1'b1);
                p[w] = 1'b0;
                fl[w] <= 1'b0;
            end
            @(posedge pclk);
        end
        fl <= 8'hff;
        setup_regs(8'hff, 1'b0);
        quiet();
        fl <= 8'h00;
        setup_regs(8'hff, 1'b1);
        for (int k = 0; k < 5; k++) begin
            alt <= 5'(1 << k);
            serve(SRC_VECTOR[ALT_SRC[k]], lv[ALT_SRC[k]], 1'b1);
        end
        alt <= 5'h04;
        apb(1'b1, OFS_UART_STATUS, 32'h20);
        quiet();
        alt <= 5'h00;
        apb(1'b1, OFS_UART_STATUS, 32'h00);
        fl <= 8'h40;
        serve(SRC_VECTOR[SRC_UART_RX], lv[SRC_UART_RX], 1'b1);
        setup_regs(8'h40, 1'b1);
        quiet();
        lv = '{2'h1, 2'h3, 2'h3, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
        setup_regs(8'h0f, 1'b1);
        fl <= 8'h08;
        serve(SRC_VECTOR[SRC_KEYPAD], 2'h1, 1'b0);
        // state view: no request, keypad index 3, level 1 in service
        apb(1'b0, OFS_STATE, 32'h0);
        `CHK(rd, 32'h0000_0032)
        fl <= 8'h01;
        quiet();
        fl <= 8'h05;
        serve(SRC_VECTOR[SRC_TIMER_A], 2'h3, 1'b0);
        fl <= 8'h03;
        quiet();
        ret_pulse();
        serve(SRC_VECTOR[SRC_WATCHDOG], 2'h3, 1'b1);
        fl <= 8'h01;
        quiet();
        ret_pulse();
        serve(SRC_VECTOR[SRC_BROWNOUT], 2'h1, 1'b1);
        power_down <= 1'b1;
        setup_regs(8'hff, 1'b1);
        for (int s = 0; s < NSRC; s++) begin
            fl <= 8'(1 << s);
            repeat (3) @(posedge pclk);
            `CHK(wake_up, SRC_WAKE[s])
        end
        wrap_up();
    end
endmodule
